// *** shared/pvfi_pkg.sv ***
`default_nettype none
package pvfi_pkg;

  localparam int PIX_W      = 24;
  localparam int FIFO_DEPTH = 8;

  // bench clock and derived pixel clock
  localparam real CLK_MHZ   = 250.0;
  localparam int  PCLK_HALF = 2;

  // line layout in pixel clocks, measured from the line sync edge
  localparam int H_SYNC  = 8;
  localparam int H_BP    = 4;
  localparam int H_ACT   = 64;
  localparam int H_FP    = 8;
  localparam int H_TOTAL = H_SYNC + H_BP + H_ACT + H_FP;
  localparam int H_DE_LO = H_SYNC + H_BP;
  localparam int H_DE_HI = H_DE_LO + H_ACT;
  localparam int HCNT_W  = 8;

  // frame layout in lines, measured from the frame sync edge
  localparam int V_SYNC  = 1;
  localparam int V_BP    = 6;
  localparam int V_ACT   = 48;
  localparam int V_FP    = 8;
  localparam int V_TOTAL = V_BP + V_ACT + V_FP;
  localparam int VCNT_W  = 7;
  localparam int MIRROR_LINES = 48;

  // timing limits the source keeps
  localparam int VSW_MIN_LINES = 1;
  localparam int VBP_MIN_LINES = 2;
  localparam int VFP_MIN_LINES = 1;
  localparam int TVB_BASE      = 6;
  localparam int TVB_SCALE     = 8;
  localparam int HSW_MIN       = 4;
  localparam int HSW_MAX       = 128;
  localparam int HBP_MIN       = 4;
  localparam int HFP_MIN       = 8;

  // chip reset pulse: least time, rounded up
  localparam real RST_PULSE_US = 1.25;
  localparam int  RST_CYCLES   = int'($ceil(RST_PULSE_US * CLK_MHZ));
  localparam int  RST_W        = 9;

  // eye select setup and hold around frame sync changes
  localparam real EYE_SETTLE_MS         = 1.0;
  localparam int  EYE_SETTLE_CYCLES_DEF = int'($ceil(EYE_SETTLE_MS * 1000.0 * CLK_MHZ));
  localparam int  SINCE_W               = 20;

  typedef struct packed {
    logic             vsync;
    logic             hsync;
    logic             valid;
    logic             eye;
    logic [PIX_W-1:0] data;
  } pvfi_pins_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_WAIT  = 2'b01,
    ST_RUN   = 2'b11
  } pvfi_state_t;

  function automatic int tvb_min(input int src_lines, input int dmd_lines);
    int ratio;
    ratio = (src_lines + dmd_lines - 1) / dmd_lines;
    if (ratio < 1)
    begin
      ratio = 1;
    end
    return TVB_BASE + TVB_SCALE * ratio;
  endfunction

  function automatic logic de_at(input logic [HCNT_W-1:0] h, input logic [VCNT_W-1:0] v);
    return (h >= H_DE_LO) && (h < H_DE_HI) && (v >= V_BP) && (v < V_BP + V_ACT);
  endfunction

endpackage
`default_nettype wire

// *** hdl/pvfi_fifo.sv ***
`default_nettype none
module pvfi_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 8
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  input  wire logic         i_wr_valid,
  input  wire logic [W-1:0] i_wr_data,
  output logic              o_wr_ready,
  output logic              o_rd_valid,
  input  wire logic         i_rd_ready,
  output logic [W-1:0]      o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   count;
  logic [AW-1:0] next_wptr;
  logic [AW-1:0] next_rptr;
  logic [AW:0]   next_count;
  logic          next_wr_ready;
  logic          push;
  logic          pop;

  assign o_rd_valid = (count != '0);
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = i_rd_ready && o_rd_valid;

  always_comb
  begin
    next_wptr  = push ? AW'((wptr + 1'b1) % DEPTH) : wptr;
    next_rptr  = pop ? AW'((rptr + 1'b1) % DEPTH) : rptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    next_wr_ready = (next_count < (AW+1)'(DEPTH));
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wptr       <= '0;
      rptr       <= '0;
      count      <= '0;
      o_wr_ready <= 1'b0;
    end
    else
    begin
      wptr       <= next_wptr;
      rptr       <= next_rptr;
      count      <= next_count;
      o_wr_ready <= next_wr_ready;
    end
  end

  // storage and registered read port
  always_ff @(posedge i_clock)
  begin
    if (push)
    begin
      mem[wptr] <= i_wr_data;
    end
    if (pop)
    begin
      o_rd_data <= mem[rptr];
    end
  end
endmodule
`default_nettype wire

// *** hdl/pvfi_source.sv ***
// Summary of operation
// [RULE_01] frame sync stays active for at least one whole line each frame
// [RULE_02] at least two lines from frame sync edge to first active line
// [RULE_03] at least one line from line edge after last active line to frame sync
// [RULE_04] back plus front porch reaches 6 plus 8 times max(1, lines ratio)
// [RULE_05] line sync stays active between 4 and 128 pixel clocks
// [RULE_06] at least 4 pixel clocks from line sync edge to data valid rise
// [RULE_07] at least 8 pixel clocks from data valid fall to next line sync
// [RULE_08] syncs, valid and 24 pixel bits stable around the active pixel clock edge
// [RULE_09] eye select settles at least 1.0 ms before frame sync changes
// [RULE_10] eye select held at least 1.0 ms after every frame sync change
// [RULE_11] chip reset driven low for at least 1.25 us
// [RULE_12] sync polarity configurable, active high by default
`default_nettype none
module pvfi_source
  import pvfi_pkg::*;
#(
  parameter int EYE_SETTLE_CYCLES = EYE_SETTLE_CYCLES_DEF
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic             i_reset_req,
  input  wire logic             i_vsync_act_high,
  input  wire logic             i_hsync_act_high,
  input  wire logic             i_eye_req,
  input  wire logic             i_pix_valid,
  input  wire logic [PIX_W-1:0] i_pix_data,
  output logic                  o_pix_ready,
  output logic                  o_pixel_clock,
  output logic                  o_chip_reset_n,
  output pvfi_pins_t            o_video,
  output logic                  o_underrun
);
  localparam int TVB_MIN = tvb_min(V_ACT, MIRROR_LINES);

  pvfi_state_t         state;
  pvfi_state_t         next_state;
  logic [HCNT_W-1:0]   h;
  logic [HCNT_W-1:0]   next_h;
  logic [HCNT_W-1:0]   h_ahead;
  logic [VCNT_W-1:0]   v;
  logic [VCNT_W-1:0]   next_v;
  logic                vs_act;
  logic                next_vs_act;
  logic                hs_act;
  logic                next_hs_act;
  logic                de_act;
  logic                next_de_act;
  logic                eye;
  logic                next_eye;
  logic [1:0]          div;
  logic [1:0]          next_div;
  logic                next_pclk;
  logic                fall_tick;
  logic                rise_tick;
  logic [RST_W-1:0]    rst_cnt;
  logic [RST_W-1:0]    next_rst_cnt;
  logic                next_chip_reset_n;
  logic                rst_pend;
  logic                next_rst_pend;
  logic [SINCE_W-1:0]  since_vs;
  logic [SINCE_W-1:0]  next_since_vs;
  logic [SINCE_W-1:0]  since_eye;
  logic [SINCE_W-1:0]  next_since_eye;
  logic                fetched;
  logic                next_fetched;
  logic                next_underrun;
  pvfi_pins_t          next_video;
  logic                pop_req;
  logic                fifo_valid;
  logic [PIX_W-1:0]    fifo_data;

  pvfi_fifo #(
    .W     (PIX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clock    (i_clock),
    .i_rst_b    (i_rst_b),
    .i_wr_valid (i_pix_valid),
    .i_wr_data  (i_pix_data),
    .o_wr_ready (o_pix_ready),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (pop_req),
    .o_rd_data  (fifo_data)
  );

  // video pin outputs move only on the falling pixel clock edge
  assign fall_tick = (div == 2'(PCLK_HALF - 1)) && o_pixel_clock; // [RULE_08]
  assign rise_tick = (div == 2'(PCLK_HALF - 1)) && !o_pixel_clock;
  assign h_ahead   = (h == HCNT_W'(H_TOTAL - 1)) ? '0 : HCNT_W'(h + 1'b1);

  always_comb
  begin
    next_state        = state;
    next_h            = h;
    next_v            = v;
    next_vs_act       = vs_act;
    next_hs_act       = hs_act;
    next_de_act       = de_act;
    next_eye          = eye;
    next_rst_cnt      = rst_cnt;
    next_chip_reset_n = o_chip_reset_n;
    next_rst_pend     = rst_pend || i_reset_req;
    next_video        = o_video;
    next_div          = fall_tick || rise_tick ? 2'h0 : 2'(div + 1'b1);
    next_pclk         = (fall_tick || rise_tick) ? !o_pixel_clock : o_pixel_clock;
    next_since_vs     = (since_vs < SINCE_W'(EYE_SETTLE_CYCLES)) ? SINCE_W'(since_vs + 1'b1) : since_vs;
    next_since_eye    = (since_eye < SINCE_W'(EYE_SETTLE_CYCLES)) ? SINCE_W'(since_eye + 1'b1) : since_eye;
    pop_req           = 1'b0;
    next_fetched      = fetched;
    next_underrun     = 1'b0;
    unique case (state)
      ST_RESET:
      begin
        next_chip_reset_n = 1'b0;
        if (rst_cnt == RST_W'(RST_CYCLES - 1)) // [RULE_11]
        begin
          next_state        = ST_WAIT;
          next_chip_reset_n = 1'b1;
          next_rst_cnt      = '0;
        end
        else
        begin
          next_rst_cnt = RST_W'(rst_cnt + 1'b1);
        end
      end
      ST_WAIT:
      begin
        // hold the new frame until the eye select has settled
        if (fall_tick && since_eye >= SINCE_W'(EYE_SETTLE_CYCLES)) // [RULE_09]
        begin
          next_state  = ST_RUN;
          next_h      = '0;
          next_v      = '0;
          next_vs_act = 1'b1;
          next_hs_act = 1'b1;
          next_de_act = 1'b0;
        end
      end
      ST_RUN:
      begin
        if (rise_tick && de_at(h_ahead, (h_ahead == '0) ? VCNT_W'(v + 1'b1) : v))
        begin
          pop_req       = 1'b1;
          next_fetched  = fifo_valid;
          next_underrun = !fifo_valid;
        end
        if (fall_tick)
        begin
          next_h = h_ahead;
          if (h_ahead == '0)
          begin
            next_v = VCNT_W'(v + 1'b1);
          end
          if (h_ahead == '0 && v == VCNT_W'(V_TOTAL - 1)) // [RULE_03] [RULE_04]
          begin
            next_state  = ST_WAIT;
            next_vs_act = 1'b0;
            next_hs_act = 1'b0;
            next_de_act = 1'b0;
          end
          else
          begin
            next_vs_act = (next_v < VCNT_W'(V_SYNC)); // [RULE_01]
            next_hs_act = (next_h < HCNT_W'(H_SYNC)); // [RULE_05]
            next_de_act = de_at(next_h, next_v); // [RULE_02] [RULE_06] [RULE_07]
          end
        end
      end
      default:
      begin
        next_state = ST_RESET;
      end
    endcase
    if (fall_tick && next_rst_pend)
    begin
      next_state        = ST_RESET;
      next_rst_cnt      = '0;
      next_chip_reset_n = 1'b0;
      next_rst_pend     = 1'b0;
      next_vs_act       = 1'b0;
      next_hs_act       = 1'b0;
      next_de_act       = 1'b0;
    end
    // eye select moves only well clear of frame sync changes
    if (fall_tick && i_eye_req != eye && !vs_act && !next_vs_act
        && since_vs >= SINCE_W'(EYE_SETTLE_CYCLES)) // [RULE_10]
    begin
      next_eye       = i_eye_req;
      next_since_eye = '0;
    end
    if (next_vs_act != vs_act)
    begin
      next_since_vs = '0;
    end
    if (fall_tick)
    begin
      next_video.vsync = next_vs_act ^ !i_vsync_act_high; // [RULE_12]
      next_video.hsync = next_hs_act ^ !i_hsync_act_high; // [RULE_12]
      next_video.valid = next_de_act;
      next_video.eye   = next_eye;
      next_video.data  = (next_de_act && fetched) ? fifo_data : 24'h00_0000; // [RULE_08]
      next_fetched     = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state          <= ST_RESET;
      h              <= '0;
      v              <= '0;
      vs_act         <= 1'b0;
      hs_act         <= 1'b0;
      de_act         <= 1'b0;
      eye            <= 1'b0;
      div            <= 2'h0;
      o_pixel_clock  <= 1'b0;
      rst_cnt        <= '0;
      o_chip_reset_n <= 1'b0;
      rst_pend       <= 1'b0;
      since_vs       <= SINCE_W'(EYE_SETTLE_CYCLES);
      since_eye      <= SINCE_W'(EYE_SETTLE_CYCLES);
      fetched        <= 1'b0;
      o_underrun     <= 1'b0;
      o_video        <= '{vsync: 1'b0, hsync: 1'b0, valid: 1'b0, eye: 1'b0, data: 24'h00_0000};
    end
    else
    begin
      state          <= next_state;
      h              <= next_h;
      v              <= next_v;
      vs_act         <= next_vs_act;
      hs_act         <= next_hs_act;
      de_act         <= next_de_act;
      eye            <= next_eye;
      div            <= next_div;
      o_pixel_clock  <= next_pclk;
      rst_cnt        <= next_rst_cnt;
      o_chip_reset_n <= next_chip_reset_n;
      rst_pend       <= next_rst_pend;
      since_vs       <= next_since_vs;
      since_eye      <= next_since_eye;
      fetched        <= next_fetched;
      o_underrun     <= next_underrun;
      o_video        <= next_video;
    end
  end

  // measurement counters read only by the checks below
  logic [15:0] vs_len;
  logic [7:0]  hs_len;
  logic [7:0]  pix_hs;
  logic [7:0]  pix_de;
  logic [7:0]  ln_vs;
  logic [7:0]  ln_de;
  logic [7:0]  vbp_seen;
  logic        frame_ok;
  logic [15:0] low_cnt;

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      vs_len   <= 16'h0000;
      hs_len   <= 8'h00;
      pix_hs   <= 8'hff;
      pix_de   <= 8'hff;
      ln_vs    <= 8'h00;
      ln_de    <= 8'hff;
      vbp_seen <= 8'h00;
      frame_ok <= 1'b0;
      low_cnt  <= 16'h0000;
    end
    else
    begin
      low_cnt <= o_chip_reset_n ? 16'h0000 : ((low_cnt == 16'hffff) ? low_cnt : 16'(low_cnt + 1'b1));
      if (fall_tick)
      begin
        vs_len <= next_vs_act ? ((vs_len == 16'hffff) ? vs_len : 16'(vs_len + 1'b1)) : 16'h0000;
        hs_len <= next_hs_act ? ((hs_len == 8'hff) ? hs_len : 8'(hs_len + 1'b1)) : 8'h00;
        pix_hs <= (next_hs_act && !hs_act) ? 8'h00 : ((pix_hs == 8'hff) ? pix_hs : 8'(pix_hs + 1'b1));
        pix_de <= (!next_de_act && de_act) ? 8'h00 : ((pix_de == 8'hff) ? pix_de : 8'(pix_de + 1'b1));
        if (next_vs_act && !vs_act)
        begin
          ln_vs <= 8'h00;
        end
        else if (next_hs_act && !hs_act && ln_vs != 8'hff)
        begin
          ln_vs <= 8'(ln_vs + 1'b1);
        end
        if (!next_de_act && de_act)
        begin
          ln_de <= 8'h00;
        end
        else if (next_hs_act && !hs_act && !next_vs_act && ln_de != 8'hff)
        begin
          ln_de <= 8'(ln_de + 1'b1);
        end
        if (next_de_act && !de_act && next_v == VCNT_W'(V_BP))
        begin
          vbp_seen <= ln_vs;
          frame_ok <= 1'b1;
        end
      end
    end
  end

  // a frame cut by a chip reset pulse is never seen by the device
  chk_vsync_width: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_01]
    ($fell(vs_act) && o_chip_reset_n) |-> $past(vs_len) >= 16'(H_TOTAL * VSW_MIN_LINES))
    else $error("frame sync shorter than one line");
  chk_back_porch: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_02]
    $rose(de_act) |-> ln_vs >= 8'(VBP_MIN_LINES))
    else $error("vertical back porch too short");
  chk_front_porch: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_03]
    $rose(vs_act) |-> ln_de >= 8'(VFP_MIN_LINES))
    else $error("vertical front porch too short");
  chk_total_blank: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_04]
    ($rose(vs_act) && frame_ok) |-> (9'(vbp_seen) + 9'(ln_de)) >= 9'(TVB_MIN))
    else $error("total vertical blanking too short");
  chk_hsync_width: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_05]
    ($fell(hs_act) && o_chip_reset_n) |-> ($past(hs_len) >= 8'(HSW_MIN) && $past(hs_len) <= 8'(HSW_MAX)))
    else $error("line sync width out of range");
  chk_horiz_back: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_06]
    $rose(de_act) |-> pix_hs >= 8'(HBP_MIN))
    else $error("horizontal back porch too short");
  chk_horiz_front: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_07]
    $rose(hs_act) |-> pix_de >= 8'(HFP_MIN))
    else $error("horizontal front porch too short");
  chk_pins_edge: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_08]
    $changed(o_video) |-> (!o_pixel_clock && $past(o_pixel_clock)) ##1 !o_pixel_clock)
    else $error("video pins changed away from falling pixel clock edge");
  chk_eye_setup: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_09]
    $changed(vs_act) |-> $past(since_eye) >= SINCE_W'(EYE_SETTLE_CYCLES - 1))
    else $error("eye select changed too close before frame sync");
  chk_eye_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_10]
    $changed(eye) |-> ($past(since_vs) >= SINCE_W'(EYE_SETTLE_CYCLES) && !vs_act))
    else $error("eye select changed too soon after frame sync");
  chk_reset_width: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_11]
    $rose(o_chip_reset_n) |-> low_cnt >= 16'(RST_CYCLES))
    else $error("chip reset pulse too short");
  chk_sync_polarity: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RULE_12]
    $past(fall_tick) |-> (o_video.vsync == (vs_act ^ !$past(i_vsync_act_high))
                          && o_video.hsync == (hs_act ^ !$past(i_hsync_act_high))))
    else $error("sync polarity does not follow configuration");
endmodule
`default_nettype wire

// *** verification/pvfi_sink_model.sv ***
`default_nettype none
module pvfi_sink_model
  import pvfi_pkg::*;
#(
  parameter int SETTLE = 200
) (
  input  wire logic             i_pclk,
  input  wire logic             i_chip_reset_n,
  input  wire pvfi_pins_t       i_video,
  input  wire logic             i_vpol,
  input  wire logic             i_hpol,
  output var logic [31:0]       o_hsw,
  output var logic [31:0]       o_hbp,
  output var logic [31:0]       o_hfp,
  output var logic [31:0]       o_vsw,
  output var logic [31:0]       o_vbp,
  output var logic [31:0]       o_vfp,
  output var logic [31:0]       o_npix,
  output var logic [31:0]       o_frames = 32'h0000_0000,
  output var logic [31:0]       o_eye_err = 32'h0000_0000,
  output var logic              o_cap_v,
  output var logic [PIX_W-1:0]  o_cap_d
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PCYC = 2 * PCLK_HALF;
  logic        vs_q, hs_q, de_q, run, line_de, seen_de;
  logic        vraw_q = 1'b0;
  logic        eye_q = 1'b0;
  logic [31:0] px, hcnt, fcnt, ln, fpc, npix;
  int          since_vs = SETTLE;
  int          since_eye = SETTLE;
  wire logic        vs    = (i_video.vsync == i_vpol);
  wire logic        hs    = (i_video.hsync == i_hpol);
  wire logic        hedge = hs && !hs_q;
  wire logic        vedge = vs && !vs_q;
  wire logic [31:0] idx   = hedge ? 32'h0000_0000 : px;
  wire logic [31:0] lnc   = vedge ? 32'h0000_0000 : (hedge ? ln + 32'h0000_0001 : ln);

  // eye select must keep clear of frame sync changes on both sides
  always @(posedge i_pclk)
  begin
    since_vs  <= (i_video.vsync != vraw_q) ? 0 : since_vs + 1;
    since_eye <= (i_video.eye != eye_q) ? 0 : since_eye + 1;
    if (i_video.eye != eye_q && (since_vs + 1) * PCYC < SETTLE)
      o_eye_err <= o_eye_err + 32'h0000_0001;
    if (i_video.vsync != vraw_q && (since_eye + 1) * PCYC < SETTLE)
      o_eye_err <= o_eye_err + 32'h0000_0001;
    vraw_q <= i_video.vsync;
    eye_q  <= i_video.eye;
  end

  // capture on the rising pixel clock and measure frame structure
  always @(posedge i_pclk)
  begin
    if (!i_chip_reset_n)
    begin
      {vs_q, hs_q, de_q, run, line_de, seen_de, o_cap_v} <= '0;
      {px, hcnt, fcnt, ln, fpc, npix} <= '0;
    end
    else
    begin
      vs_q    <= vs;
      hs_q    <= hs;
      de_q    <= i_video.valid;
      px      <= idx + 32'h0000_0001;
      ln      <= lnc;
      hcnt    <= hedge ? 32'h0000_0001 : hcnt + 32'(hs);
      if (!hs && hs_q)
        o_hsw <= hcnt;
      if (i_video.valid && !de_q)
        o_hbp <= idx;
      fcnt    <= (!i_video.valid && de_q) ? 32'h0000_0001 : fcnt + 32'h0000_0001;
      line_de <= hedge ? i_video.valid : (line_de | i_video.valid);
      if (hedge && line_de)
        o_hfp <= fcnt;
      if (hedge)
        fpc <= line_de ? 32'h0000_0000 : fpc + 32'h0000_0001;
      if (!vs && vs_q)
        o_vsw <= lnc;
      seen_de <= vedge ? 1'b0 : (seen_de | i_video.valid);
      if (i_video.valid && !seen_de)
        o_vbp <= lnc;
      npix    <= vedge ? 32'h0000_0000 : npix + 32'(i_video.valid);
      if (vedge)
      begin
        run   <= 1'b1;
        o_vfp <= fpc + 32'h0000_0001;
      end
      if (vedge && run)
      begin
        o_npix   <= npix;
        o_frames <= o_frames + 32'h0000_0001;
      end
      o_cap_v <= i_video.valid;
      o_cap_d <= i_video.data;
    end
  end
endmodule
`default_nettype wire

// *** verification/pvfi_source_tb.sv ***
`default_nettype none
module pvfi_source_tb
  import pvfi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SETTLE = 200;
  localparam int PCYC   = 2 * PCLK_HALF;
  localparam int RATIO  = (V_ACT + MIRROR_LINES - 1) / MIRROR_LINES;
  localparam int TVB    = TVB_BASE + TVB_SCALE * (RATIO > 1 ? RATIO : 1);

  logic             i_clock = 1'b0;
  logic             i_rst_b = 1'b0;
  logic             reset_req = 1'b0;
  logic             vpol = 1'b1;
  logic             hpol = 1'b1;
  logic             eye_req = 1'b0;
  logic             pix_valid = 1'b0;
  logic             feed_en = 1'b1;
  logic             allow_zero = 1'b0;
  logic             zero_seen = 1'b0;
  logic             have_prev = 1'b1;
  logic [PIX_W-1:0] pix_data = 24'h00_0001;
  logic [PIX_W-1:0] prev_d = 24'h00_0000;
  logic [31:0]      wr_count = 32'h0000_0000;
  int               fails = 0;
  int               check_count = 0;
  logic             pix_ready, pclk, chip_rst_n, underrun, cap_v;
  pvfi_pins_t       video;
  logic [PIX_W-1:0] cap_d;
  logic [31:0]      m_hsw, m_hbp, m_hfp, m_vsw, m_vbp, m_vfp, m_npix, m_frames, m_eye_err;

  always #2 i_clock = ~i_clock;

  pvfi_source #(.EYE_SETTLE_CYCLES(SETTLE)) u_dut (
    .i_clock          (i_clock),
    .i_rst_b          (i_rst_b),
    .i_reset_req      (reset_req),
    .i_vsync_act_high (vpol),
    .i_hsync_act_high (hpol),
    .i_eye_req        (eye_req),
    .i_pix_valid      (pix_valid),
    .i_pix_data       (pix_data),
    .o_pix_ready      (pix_ready),
    .o_pixel_clock    (pclk),
    .o_chip_reset_n   (chip_rst_n),
    .o_video          (video),
    .o_underrun       (underrun)
  );

  pvfi_sink_model #(.SETTLE(SETTLE)) u_sink (
    .i_pclk         (pclk),
    .i_chip_reset_n (chip_rst_n),
    .i_video        (video),
    .i_vpol         (vpol),
    .i_hpol         (hpol),
    .o_hsw          (m_hsw),
    .o_hbp          (m_hbp),
    .o_hfp          (m_hfp),
    .o_vsw          (m_vsw),
    .o_vbp          (m_vbp),
    .o_vfp          (m_vfp),
    .o_npix         (m_npix),
    .o_frames       (m_frames),
    .o_eye_err      (m_eye_err),
    .o_cap_v        (cap_v),
    .o_cap_d        (cap_d)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic timeout(input string what);
    fails++;
    $display("MISMATCH at %0t: wait for %s ran out, got %h expected %h", $time, what, 1'b0, 1'b1);
    tally_and_finish();
  endtask

  // writer keeps a held word until the fifo takes it
  always @(posedge i_clock)
  begin
    if (pix_valid && pix_ready)
    begin
      wr_count <= wr_count + 32'h0000_0001;
      pix_data <= pix_data + 24'h00_0001;
    end
    pix_valid <= feed_en || (pix_valid && !pix_ready);
  end

  // captured pixels must follow the written order
  always @(posedge pclk)
  begin
    if (!chip_rst_n)
      have_prev <= 1'b0;
    else if (cap_v && cap_d === 24'h00_0000 && allow_zero)
      zero_seen <= 1'b1;
    else if (cap_v)
    begin
      chk({8'h00, cap_d}, {8'h00, have_prev ? prev_d + 24'h00_0001 : cap_d});
      have_prev <= 1'b1;
      prev_d    <= cap_d;
    end
  end

  task automatic frame_checks(input string name);
    int          n;
    logic [31:0] f;
    f = m_frames;
    n = 0;
    while (m_frames === f && n < 50000)
    begin
      @(posedge i_clock);
      n++;
    end
    if (n == 50000)
      timeout(name);
    chk(m_hsw, H_SYNC);
    chk1(m_hsw >= HSW_MIN && m_hsw <= HSW_MAX, 1'b1);
    chk(m_hbp, H_DE_LO);
    chk(m_hfp, H_FP);
    chk(m_vsw, V_SYNC);
    chk(m_vbp, V_BP);
    chk(m_vfp, V_FP);
    chk1(m_vbp + m_vfp >= TVB, 1'b1);
    chk(m_npix, V_ACT * H_ACT);
    chk(m_eye_err, 32'h0000_0000);
  endtask

  task automatic t_fill();
    repeat (60) @(posedge i_clock);
    chk1(pix_ready, 1'b0);
    chk(wr_count, FIFO_DEPTH);
    $display("test fifo fill done");
  endtask

  task automatic t_rst_pulse(input int start, input int extra);
    int         lo;
    logic [1:0] sy;
    lo = start;
    sy = 2'b00;
    while (chip_rst_n !== 1'b1 && lo < 1000)
    begin
      sy = {video.vsync, video.hsync};
      @(posedge i_clock);
      lo++;
    end
    if (lo == 1000)
      timeout("chip reset release");
    chk1(lo >= RST_CYCLES && lo <= RST_CYCLES + extra, 1'b1);
    chk({30'h0, sy}, {30'h0, ~vpol, ~hpol});
    $display("test chip reset pulse done");
  endtask

  task automatic t_eye();
    eye_req <= 1'b1;
    frame_checks("eye frame");
    chk1(video.eye, 1'b1);
    $display("test eye select frame done");
  endtask

  task automatic t_underrun();
    int   n;
    logic seen;
    n = 0;
    seen = 1'b0;
    while (video.valid !== 1'b1 && n < 30000)
    begin
      @(posedge i_clock);
      n++;
    end
    feed_en    <= 1'b0;
    allow_zero <= 1'b1;
    n = 0;
    while (!seen && n < 400)
    begin
      @(posedge i_clock);
      seen = (underrun === 1'b1);
      n++;
    end
    feed_en <= 1'b1;
    chk1(seen, 1'b1);
    frame_checks("underrun frame");
    chk1(zero_seen, 1'b1);
    allow_zero <= 1'b0;
    $display("test underrun done");
  endtask

  task automatic t_polarity();
    int n;
    reset_req <= 1'b1;
    @(posedge i_clock);
    reset_req <= 1'b0;
    n = 0;
    while (chip_rst_n !== 1'b0 && n < 16)
    begin
      @(posedge i_clock);
      n++;
    end
    if (n == 16)
      timeout("chip reset start");
    vpol <= 1'b0;
    hpol <= 1'b0;
    t_rst_pulse(0, 1);
    frame_checks("low polarity frame");
    $display("test sync polarity done");
  endtask

  initial
  begin
    repeat (2) @(posedge i_clock);
    i_rst_b <= 1'b1;
    t_fill();
    t_rst_pulse(60, PCYC);
    t_eye();
    t_underrun();
    t_polarity();
    tally_and_finish();
  end
endmodule
`default_nettype wire
